/* rtl/carrier_regs_pkg.sv */
package carrier_regs_pkg;
	// I/O space (BAR1) register offsets, byte addresses
	localparam logic [7:0] IO_SERIAL_DATA = 8'h10;
	localparam logic [7:0] IO_SERIAL_CTRL = 8'h14;
	localparam logic [7:0] IO_SERIAL_ICTL = 8'h18;
	localparam logic [7:0] IO_IRQ_ENABLE = 8'h40;
	localparam logic [7:0] IO_CLK_PROG_A = 8'h60;
	localparam logic [7:0] IO_CLK_PROG_B = 8'h64;
	localparam logic [7:0] IO_SCAN_LO = 8'h80;
	localparam logic [7:0] IO_SCAN_HI = 8'hAF;
	// memory space (BAR2) decode
	localparam logic [31:0] MEM_SRAM_BASE = 32'h0000_0000;
	localparam logic [31:0] MEM_SRAM_LAST = 32'h000F_FFFF;
	localparam logic [31:0] MEM_DMA_SRAM_BASE = 32'h4000_0000;
	// word line a28 of the bridge is byte address bit 30
	localparam int DMA_ADDR_BIT = 30;
	localparam logic [31:0] MEM_GBUS_LO = 32'h0020_0000;
	localparam logic [31:0] MEM_GBUS_HI = 32'h0020_007F;
	localparam logic [31:0] MEM_MIR_DATA = 32'h0020_0090;
	localparam logic [31:0] MEM_MIR_CTRL = 32'h0020_0094;
	localparam logic [31:0] MEM_MIR_ICTL = 32'h0020_0098;
	localparam logic [31:0] MEM_PBB_DATA_LO = 32'h0020_0240;
	localparam logic [31:0] MEM_PBB_DATA_HI = 32'h0020_025F;
	localparam logic [31:0] MEM_PBB_CTRL_HI = 32'h0020_027F;
	// local bus map seen by the module master
	localparam logic [31:0] LB_AP0_LO = 32'h1800_0000;
	localparam logic [31:0] LB_AP0_HI = 32'h183F_FFFF;
	localparam logic [31:0] LB_AP1_LO = 32'h1400_0000;
	localparam logic [31:0] LB_AP1_HI = 32'h17FF_FFFF;
	localparam logic [31:0] LB_BRG_LO = 32'h1C00_0000;
	localparam logic [31:0] LB_BRG_HI = 32'h1C00_00FF;
	localparam logic [31:0] LB_SRAM_LO = 32'hD000_0000;
	localparam logic [31:0] LB_SRAM_HI = 32'hD00F_FFFF;
	// module site select lines for the global bus window
	localparam int SITE_HI_A = 30;
	localparam int SITE_HI_B = 19;
	localparam int SITE_LO_A = 7;
	localparam int SITE_LO_B = 5;
	// field layouts and reset values
	localparam int IRQ_LINES = 3;
	localparam int NIB = 4;
	localparam logic [15:0] CLK_A_RESET = 16'h0000;
	localparam logic [7:0] CLK_B_RESET = 8'h00;
	localparam logic [2:0] IRQ_EN_RESET = 3'h0;
	// phase-shift step: 1/(100 MHz * 16) = 625 ps
	localparam int PHASE_STEP_PS = 625;
	localparam int PHASE_NOM_MHZ = 100;
	localparam int PHASE_STEPS = 16;

	// one host access (I/O or memory space)
	typedef struct packed {
		logic io_space;
		logic wr;
		logic rd;
		logic [31:0] addr;
		logic [31:0] wdata;
	} host_req_t;

	// memory-space region hit flags
	typedef struct packed {
		logic sram;
		logic gbus;
		logic pbb_data;
		logic pbb_ctrl;
		logic none;
	} mem_sel_t;

	// local bus region hit flags
	typedef struct packed {
		logic ap0;
		logic ap1;
		logic bridge;
		logic sram;
		logic none;
	} lb_sel_t;

	// per-bank clock program: frequency and phase codes
	typedef struct packed {
		logic [3:0] freq;
		logic [3:0] phase;
	} clk_prog_t;
endpackage : carrier_regs_pkg

/* rtl/carrier_board_register_decoder.sv */
// Contract
// - mailbox read/write events from local side raise a host interrupt request
// - three enable bits 2..0 gate host-to-DSP interrupt onto matching module line
// - host reaches each register at a fixed offset from its allocated I/O base
// - memory 00200090 mirrors serial data: write outgoing, read incoming
// - memory 00200094 mirrors serial control on write, status on read
// - memory 00200098 mirrors serial interrupt control register
// - shared SRAM at 00000000, DMA reaches it from 40000000 with A28 high
// - 00200000..0020007F forwarded to global bus when site lines decode
// - 00200240..0020025F selects parallel bus data, up to 0020027F its control
// - local master sees apertures 0,1, bridge registers and SRAM at fixed bases
// - three separately programmable bank clocks, banks two, three and four
// - clocks configured only through programming registers at offsets 60 and 64
// - reg A bits 7..4 bank-two frequency, bits 3..0 bank-two phase
// - phase codes step in 625 ps units, 100 MHz over 16 steps
`timescale 1ns/1ns
module carrier_board_register_decoder
	import carrier_regs_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	// host access, already synchronous to core_clk_in via the bridge local bus
	input wire logic host_wr_in,
	input wire logic host_rd_in,
	input wire logic host_io_space_in,
	input wire logic [31:0] host_addr_in,
	input wire logic [31:0] host_wdata_in,
	output logic [31:0] host_rdata_out,
	output logic host_ack_out,
	// serial port engine
	input wire logic [31:0] serial_in_data_in,
	input wire logic [31:0] serial_status_in,
	output logic [31:0] serial_out_data_out,
	output logic serial_out_wr_out,
	output logic [31:0] serial_control_out,
	output logic serial_control_wr_out,
	output logic [31:0] serial_int_control_out,
	output logic serial_in_rd_out,
	// scan controller window
	input wire logic [15:0] scan_rdata_in,
	output logic scan_wr_out,
	output logic scan_rd_out,
	// memory-space region selects
	output logic sram_sel_out,
	output logic [19:0] sram_addr_out,
	output logic gbus_sel_out,
	output logic pbb_data_sel_out,
	output logic pbb_ctrl_sel_out,
	// module site address lines (pins, synchronised here)
	input wire logic site_address_line_30_in,
	input wire logic site_address_line_19_in,
	input wire logic site_address_line_7_in,
	input wire logic site_address_line_5_in,
	// local bus master address decode
	input wire logic lb_valid_in,
	input wire logic [31:0] lb_addr_in,
	output logic lb_ap0_sel_out,
	output logic lb_ap1_sel_out,
	output logic lb_bridge_sel_out,
	output logic lb_sram_sel_out,
	// interrupts
	input wire logic host_to_dsp_irq_in,
	input wire logic mailbox_wr_evt_in,
	input wire logic mailbox_rd_evt_in,
	input wire logic board_irq_src_in,
	output logic host_irq_out,
	output logic [2:0] dsp_irq_line_out,
	// clock synthesizer programming
	output logic [7:0] second_bank_clock_prog_out,
	output logic [7:0] third_bank_clock_prog_out,
	output logic [7:0] fourth_bank_clock_prog_out
);
	host_req_t req;
	mem_sel_t msel;
	lb_sel_t lsel;
	logic [2:0] irq_en_r;
	logic [15:0] clk_a_r;
	logic [7:0] clk_b_r;
	logic [31:0] int_ctl_r;
	logic [31:0] ctrl_r;
	logic [31:0] rdata_nxt;
	logic [3:0] site_meta_r;
	logic [3:0] site_sync_r;

	// phase unit kept as a derived constant so firmware tables can cite it
	localparam int PHASE_UNIT_PS = 1_000_000 / (PHASE_NOM_MHZ * PHASE_STEPS);

	assign req = '{io_space: host_io_space_in, wr: host_wr_in, rd: host_rd_in,
		addr: host_addr_in, wdata: host_wdata_in};

	// I/O-space decode: offsets relative to the allocated base, bridge strips base
	wire [7:0] io_off = req.addr[7:0];
	wire io_acc = req.io_space && (req.wr || req.rd);
	wire mem_acc = !req.io_space && (req.wr || req.rd);
	wire hit_data_io = io_acc && io_off == IO_SERIAL_DATA;
	wire hit_ctrl_io = io_acc && io_off == IO_SERIAL_CTRL;
	wire hit_ictl_io = io_acc && io_off == IO_SERIAL_ICTL;
	wire hit_irq_en = io_acc && io_off == IO_IRQ_ENABLE;
	wire hit_clk_a = io_acc && io_off == IO_CLK_PROG_A;
	wire hit_clk_b = io_acc && io_off == IO_CLK_PROG_B;
	wire hit_scan = io_acc && io_off >= IO_SCAN_LO && io_off <= IO_SCAN_HI;

	// memory-space mirrors behave exactly like their I/O counterparts
	wire hit_data_mir = mem_acc && req.addr == MEM_MIR_DATA;
	wire hit_ctrl_mir = mem_acc && req.addr == MEM_MIR_CTRL;
	wire hit_ictl_mir = mem_acc && req.addr == MEM_MIR_ICTL;
	wire hit_data = hit_data_io || hit_data_mir;
	wire hit_ctrl = hit_ctrl_io || hit_ctrl_mir;
	wire hit_ictl = hit_ictl_io || hit_ictl_mir;

	// SRAM: normal window at base, DMA alias with word line a28 (byte bit 30) set
	wire [31:0] sram_off = req.addr & ~MEM_DMA_SRAM_BASE;
	wire dma_alias = req.addr[DMA_ADDR_BIT];
	wire sram_hit = mem_acc && sram_off >= MEM_SRAM_BASE && sram_off <= MEM_SRAM_LAST
		&& (req.addr == sram_off || dma_alias);

	// global bus only answers when this site's select lines are strapped right
	wire site_ok = site_sync_r[3] && site_sync_r[2] && !site_sync_r[1] && !site_sync_r[0];
	wire gbus_hit = mem_acc && req.addr >= MEM_GBUS_LO && req.addr <= MEM_GBUS_HI
		&& site_ok;
	wire pbb_d_hit = mem_acc && req.addr >= MEM_PBB_DATA_LO
		&& req.addr <= MEM_PBB_DATA_HI;
	wire pbb_c_hit = mem_acc && req.addr > MEM_PBB_DATA_HI
		&& req.addr <= MEM_PBB_CTRL_HI;

	assign msel = '{sram: sram_hit, gbus: gbus_hit, pbb_data: pbb_d_hit,
		pbb_ctrl: pbb_c_hit, none: mem_acc && !(sram_hit || gbus_hit || pbb_d_hit
		|| pbb_c_hit || hit_data_mir || hit_ctrl_mir || hit_ictl_mir)};

	// local bus master map, decoded in parallel with host traffic
	wire la0 = lb_valid_in && lb_addr_in >= LB_AP0_LO && lb_addr_in <= LB_AP0_HI;
	wire la1 = lb_valid_in && lb_addr_in >= LB_AP1_LO && lb_addr_in <= LB_AP1_HI;
	wire lbr = lb_valid_in && lb_addr_in >= LB_BRG_LO && lb_addr_in <= LB_BRG_HI;
	wire lsr = lb_valid_in && lb_addr_in >= LB_SRAM_LO
		&& lb_addr_in <= LB_SRAM_HI;
	assign lsel = '{ap0: la0, ap1: la1, bridge: lbr, sram: lsr,
		none: lb_valid_in && !(la0 || la1 || lbr || lsr)};

	// readback mux; control and interrupt-control are write-only so read status/zero
	always_comb begin
		rdata_nxt = '0;
		if (hit_data) begin
			rdata_nxt = serial_in_data_in;
		end else if (hit_ctrl) begin
			rdata_nxt = serial_status_in;
		end else if (hit_irq_en) begin
			rdata_nxt = {29'h0000_0000, irq_en_r};
		end else if (hit_clk_a) begin
			rdata_nxt = {16'h0000, clk_a_r};
		end else if (hit_clk_b) begin
			rdata_nxt = {24'h00_0000, clk_b_r};
		end else if (hit_scan) begin
			rdata_nxt = {16'h0000, scan_rdata_in};
		end
	end

	// site strap lines come from connector pins: two-stage synchroniser
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			site_meta_r <= 4'h0;
			site_sync_r <= 4'h0;
		end else begin
			site_meta_r <= {site_address_line_30_in, site_address_line_19_in,
				site_address_line_7_in, site_address_line_5_in};
			site_sync_r <= site_meta_r;
		end
	end

	// writable registers; only low three enable bits exist
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			irq_en_r <= IRQ_EN_RESET;
			clk_a_r <= CLK_A_RESET;
			clk_b_r <= CLK_B_RESET;
			int_ctl_r <= 32'h0000_0000;
			ctrl_r <= 32'h0000_0000;
		end else begin
			if (hit_irq_en && req.wr) irq_en_r <= req.wdata[IRQ_LINES-1:0];
			if (hit_clk_a && req.wr) clk_a_r <= req.wdata[15:0];
			if (hit_clk_b && req.wr) clk_b_r <= req.wdata[7:0];
			if (hit_ictl && req.wr) int_ctl_r <= req.wdata;
			if (hit_ctrl && req.wr) ctrl_r <= req.wdata;
		end
	end

	// host answer and serial strobes, all registered one cycle after the access
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			host_rdata_out <= 32'h0000_0000;
			host_ack_out <= 1'b0;
			serial_out_data_out <= 32'h0000_0000;
			serial_out_wr_out <= 1'b0;
			serial_control_wr_out <= 1'b0;
			serial_in_rd_out <= 1'b0;
			scan_wr_out <= 1'b0;
			scan_rd_out <= 1'b0;
		end else begin
			host_rdata_out <= req.rd ? rdata_nxt : 32'h0000_0000;
			host_ack_out <= io_acc || mem_acc; // unmapped accesses still complete
			if (hit_data && req.wr) serial_out_data_out <= req.wdata;
			serial_out_wr_out <= hit_data && req.wr;
			serial_control_wr_out <= hit_ctrl && req.wr;
			serial_in_rd_out <= hit_data && req.rd;
			scan_wr_out <= hit_scan && req.wr;
			scan_rd_out <= hit_scan && req.rd;
		end
	end

	// region selects are registered so the strobes line up with the ack
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			sram_sel_out <= 1'b0;
			sram_addr_out <= 20'h0_0000;
			gbus_sel_out <= 1'b0;
			pbb_data_sel_out <= 1'b0;
			pbb_ctrl_sel_out <= 1'b0;
			lb_ap0_sel_out <= 1'b0;
			lb_ap1_sel_out <= 1'b0;
			lb_bridge_sel_out <= 1'b0;
			lb_sram_sel_out <= 1'b0;
		end else begin
			sram_sel_out <= msel.sram;
			sram_addr_out <= sram_off[19:0];
			gbus_sel_out <= msel.gbus;
			pbb_data_sel_out <= msel.pbb_data;
			pbb_ctrl_sel_out <= msel.pbb_ctrl;
			lb_ap0_sel_out <= lsel.ap0;
			lb_ap1_sel_out <= lsel.ap1;
			lb_bridge_sel_out <= lsel.bridge;
			lb_sram_sel_out <= lsel.sram;
		end
	end

	// interrupt routing: host request reaches each DSP line only when enabled
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			host_irq_out <= 1'b0;
			dsp_irq_line_out <= 3'h0;
		end else begin
			host_irq_out <= mailbox_wr_evt_in || mailbox_rd_evt_in
				|| board_irq_src_in;
			dsp_irq_line_out <= {IRQ_LINES{host_to_dsp_irq_in}} & irq_en_r;
		end
	end

	// per-bank clock programs fanned out from the two registers
	clk_prog_t bank2;
	clk_prog_t bank3;
	clk_prog_t bank4;
	assign bank2 = '{freq: clk_a_r[7:4], phase: clk_a_r[3:0]};
	assign bank3 = '{freq: clk_a_r[15:12], phase: clk_a_r[11:8]};
	assign bank4 = '{freq: clk_b_r[7:4], phase: clk_b_r[3:0]};
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			second_bank_clock_prog_out <= 8'h00;
			third_bank_clock_prog_out <= 8'h00;
			fourth_bank_clock_prog_out <= 8'h00;
		end else begin
			second_bank_clock_prog_out <= bank2;
			third_bank_clock_prog_out <= bank3;
			fourth_bank_clock_prog_out <= bank4;
		end
	end

	// control/interrupt-control values held for the serial engine
	assign serial_control_out = ctrl_r;
	assign serial_int_control_out = int_ctl_r;
endmodule : carrier_board_register_decoder

/* tb/carrier_host_model.sv */
`timescale 1ns/1ns
// host behind the bridge: one-cycle request strobe, then waits for the acknowledge
module carrier_host_model
	import carrier_regs_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic go_in,
	input wire host_req_t req_in,
	input wire logic host_ack_in,
	input wire logic [31:0] host_rdata_in,
	output host_req_t bus_out,
	output logic busy_out,
	output logic [31:0] rdata_out
);
	// released address and data lines flip every cycle so a stale address never looks valid
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			bus_out <= '0;
			busy_out <= 1'b0;
			rdata_out <= '0;
		end else if (go_in && !busy_out) begin
			bus_out <= req_in;
			busy_out <= 1'b1;
		end else begin
			bus_out <= {bus_out.io_space, 2'b00, ~bus_out.addr, ~bus_out.wdata};
			if (host_ack_in) begin
				busy_out <= 1'b0;
				rdata_out <= host_rdata_in;
			end
		end
	end
endmodule : carrier_host_model

/* tb/carrier_regs_chk_sva.sv */
`timescale 1ns/1ns
// watches the decoder's ports only; attached by the bind below
module carrier_regs_chk
	import carrier_regs_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic host_wr_in,
	input wire logic host_rd_in,
	input wire logic host_io_space_in,
	input wire logic [31:0] host_addr_in,
	input wire logic [31:0] host_wdata_in,
	input wire logic host_ack_out,
	input wire logic [31:0] serial_out_data_out,
	input wire logic [31:0] serial_control_out,
	input wire logic sram_sel_out,
	input wire logic [19:0] sram_addr_out,
	input wire logic lb_valid_in,
	input wire logic [31:0] lb_addr_in,
	input wire logic lb_ap0_sel_out,
	input wire logic host_to_dsp_irq_in,
	input wire logic mailbox_wr_evt_in,
	input wire logic mailbox_rd_evt_in,
	input wire logic board_irq_src_in,
	input wire logic host_irq_out,
	input wire logic [2:0] dsp_irq_line_out,
	input wire logic [7:0] second_bank_clock_prog_out,
	input wire logic [7:0] third_bank_clock_prog_out
);
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);
	// access qualifiers; word line a28 is byte address bit 30 for the dma window
	wire mem_wr = host_wr_in && !host_io_space_in;
	wire mem_acc = (host_wr_in || host_rd_in) && !host_io_space_in;
	wire in_sram = host_addr_in <= MEM_SRAM_LAST ||
		host_addr_in inside {[MEM_DMA_SRAM_BASE:MEM_DMA_SRAM_BASE + MEM_SRAM_LAST]};
	property p_ack; 1'b1 |=> host_ack_out == $past(host_wr_in || host_rd_in); endproperty
	a_ack: assert property (p_ack) else $error("ack late or spurious");
	property p_mir_data; mem_wr && host_addr_in == MEM_MIR_DATA
		|=> serial_out_data_out == $past(host_wdata_in); endproperty
	a_mir_data: assert property (p_mir_data) else $error("data mirror lost");
	property p_mir_ctrl; mem_wr && host_addr_in == MEM_MIR_CTRL
		|=> serial_control_out == $past(host_wdata_in); endproperty
	a_mir_ctrl: assert property (p_mir_ctrl) else $error("control mirror lost");
	property p_sram; mem_acc && in_sram
		|=> sram_sel_out && sram_addr_out == $past(host_addr_in[19:0]); endproperty
	a_sram: assert property (p_sram) else $error("shared memory not selected");
	property p_lb_ap0; lb_valid_in && lb_addr_in inside {[LB_AP0_LO:LB_AP0_HI]}
		|=> lb_ap0_sel_out; endproperty
	a_lb_ap0: assert property (p_lb_ap0) else $error("aperture 0 missed");
	property p_host_irq; 1'b1 |=> host_irq_out ==
		$past(mailbox_wr_evt_in || mailbox_rd_evt_in || board_irq_src_in); endproperty
	a_host_irq: assert property (p_host_irq) else $error("host irq wrong");
	property p_irq_gate; !host_to_dsp_irq_in |=> dsp_irq_line_out == 3'h0; endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("dsp irq without cause");
	property p_clk_a; host_wr_in && host_io_space_in && host_addr_in[7:0] == IO_CLK_PROG_A
		|-> ##2 {third_bank_clock_prog_out, second_bank_clock_prog_out}
		== $past(host_wdata_in[15:0], 2); endproperty
	a_clk_a: assert property (p_clk_a) else $error("bank clock fields");
endmodule : carrier_regs_chk

bind carrier_board_register_decoder carrier_regs_chk i_chk (.core_clk_in, .sys_rst_in,
	.host_wr_in, .host_rd_in, .host_io_space_in, .host_addr_in, .host_wdata_in, .host_ack_out,
	.serial_out_data_out, .serial_control_out, .sram_sel_out, .sram_addr_out, .lb_valid_in,
	.lb_addr_in, .lb_ap0_sel_out, .host_to_dsp_irq_in, .mailbox_wr_evt_in, .mailbox_rd_evt_in,
	.board_irq_src_in, .host_irq_out, .dsp_irq_line_out, .second_bank_clock_prog_out,
	.third_bank_clock_prog_out);

/* tb/test_carrier_board_register_decoder.sv */
`timescale 1ns/1ns
module test_carrier_board_register_decoder;
	import carrier_regs_pkg::*;
	logic core_clk_in = 0, sys_rst_in = 1, go = 0, busy, host_ack_out, host_irq_out;
	logic [31:0] serial_in_data_in = 0, serial_status_in = 0, lb_addr_in = 0, rdata, host_rdata_out;
	logic [31:0] serial_out_data_out, serial_control_out, serial_int_control_out, a, b, w;
	logic [15:0] scan_rdata_in = 0;
	logic sram_sel_out, gbus_sel_out, pbb_data_sel_out, pbb_ctrl_sel_out, scan_wr_out, scan_rd_out;
	logic serial_out_wr_out, serial_control_wr_out, serial_in_rd_out;
	logic [8:0] seen = '0;
	logic lb_valid_in = 0, host_to_dsp_irq_in = 0, mailbox_wr_evt_in = 0, mailbox_rd_evt_in = 0;
	logic board_irq_src_in = 0, site_address_line_30_in = 0, site_address_line_19_in = 0;
	logic site_address_line_7_in = 0, site_address_line_5_in = 0;
	logic lb_ap0_sel_out, lb_ap1_sel_out, lb_bridge_sel_out, lb_sram_sel_out;
	logic [2:0] dsp_irq_line_out, en;
	logic [7:0] second_bank_clock_prog_out, third_bank_clock_prog_out, fourth_bank_clock_prog_out;
	logic [31:0] edges [6] = '{LB_AP0_LO, LB_AP0_HI + 32'h1, LB_AP1_HI, LB_BRG_HI,
		LB_BRG_HI + 32'h1, LB_SRAM_HI};
	host_req_t req = '0, bus;
	integer seed = 32'h223a, error_cnt = 0, n_tests = 0, i, k;

	carrier_host_model i_host (.core_clk_in, .sys_rst_in, .go_in(go), .req_in(req),
		.host_ack_in(host_ack_out), .host_rdata_in(host_rdata_out), .bus_out(bus),
		.busy_out(busy), .rdata_out(rdata));
	carrier_board_register_decoder i_dut (.core_clk_in, .sys_rst_in, .host_wr_in(bus.wr),
		.host_rd_in(bus.rd), .host_io_space_in(bus.io_space), .host_addr_in(bus.addr),
		.host_wdata_in(bus.wdata), .host_rdata_out, .host_ack_out, .serial_in_data_in,
		.serial_status_in, .serial_out_data_out, .serial_out_wr_out, .serial_control_out,
		.serial_control_wr_out, .serial_int_control_out, .serial_in_rd_out, .scan_rdata_in,
		.scan_wr_out, .scan_rd_out, .sram_sel_out, .sram_addr_out(), .gbus_sel_out,
		.pbb_data_sel_out, .pbb_ctrl_sel_out, .site_address_line_30_in,
		.site_address_line_19_in, .site_address_line_7_in, .site_address_line_5_in,
		.lb_valid_in, .lb_addr_in, .lb_ap0_sel_out, .lb_ap1_sel_out, .lb_bridge_sel_out,
		.lb_sram_sel_out, .host_to_dsp_irq_in, .mailbox_wr_evt_in, .mailbox_rd_evt_in,
		.board_irq_src_in, .host_irq_out, .dsp_irq_line_out, .second_bank_clock_prog_out,
		.third_bank_clock_prog_out, .fourth_bank_clock_prog_out);

	initial forever #5 core_clk_in = ~core_clk_in;

	// one-cycle strobes and selects gathered since the model took the last request
	always @(posedge core_clk_in) begin
		seen <= go ? 9'h000 : seen | {sram_sel_out, gbus_sel_out, pbb_data_sel_out,
			pbb_ctrl_sel_out, scan_wr_out, scan_rd_out, serial_out_wr_out,
			serial_control_wr_out, serial_in_rd_out};
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			error_cnt++;
		end
	endtask : chk

	// one access through the host model; a hung handshake shows as busy still set
	task automatic acc(input logic io, input logic wr, input logic [31:0] ad, input logic [31:0] d);
		@(posedge core_clk_in);
		req <= '{io_space: io, wr: wr, rd: !wr, addr: ad, wdata: d};
		go <= 1'b1;
		@(posedge core_clk_in);
		go <= 1'b0;
		k = 0;
		do begin
			@(negedge core_clk_in);
			k++;
		end while (busy && k < 20);
		chk({31'h0, busy}, 32'h0);
	endtask : acc

	// expected one-hot {ap0, ap1, bridge, sram} for a local bus address
	function automatic logic [31:0] exp_lb(input logic [31:0] ad);
		exp_lb = {28'h0, ad inside {[LB_AP0_LO:LB_AP0_HI]}, ad inside {[LB_AP1_LO:LB_AP1_HI]},
			ad inside {[LB_BRG_LO:LB_BRG_HI]}, ad inside {[LB_SRAM_LO:LB_SRAM_HI]}};
	endfunction : exp_lb

	task automatic print_verdict;
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict

	// watchdog sized well past the few hundred cycles the sequence needs
	initial begin
		#200000;
		error_cnt++;
		print_verdict();
	end

	initial begin
		repeat (5) @(posedge core_clk_in);
		sys_rst_in <= 1'b0;
		// enable register, all-ones first so the reserved bits are written
		for (i = 0; i < 4; i++) begin
			w = (i == 0) ? 32'hFFFF_FFFF : $random(seed);
			acc(1'b1, 1'b1, {24'h0, IO_IRQ_ENABLE}, w);
			acc(1'b1, 1'b0, {24'h0, IO_IRQ_ENABLE}, 32'h0);
			chk(rdata, {29'h0, w[2:0]});
		end
		en = w[2:0];
		// clock program registers, read back and on the bank outputs
		for (i = 0; i < 4; i++) begin
			a = $random(seed);
			b = $random(seed);
			acc(1'b1, 1'b1, {24'h0, IO_CLK_PROG_A}, a);
			acc(1'b1, 1'b1, {24'h0, IO_CLK_PROG_B}, b);
			acc(1'b1, 1'b0, {24'h0, IO_CLK_PROG_A}, 32'h0);
			chk(rdata, {16'h0, a[15:0]});
			acc(1'b1, 1'b0, {24'h0, IO_CLK_PROG_B}, 32'h0);
			chk(rdata, {24'h0, b[7:0]});
			w = {8'h0, fourth_bank_clock_prog_out, third_bank_clock_prog_out,
				second_bank_clock_prog_out};
			chk(w, {8'h0, b[7:0], a[15:0]});
		end
		// serial mirrors against their i/o-space originals
		@(posedge core_clk_in);
		w = $random(seed);
		serial_in_data_in <= $random(seed);
		serial_status_in <= $random(seed);
		scan_rdata_in <= w[31:16];
		{site_address_line_30_in, site_address_line_19_in} <= 2'b11;
		acc(1'b0, 1'b1, MEM_MIR_DATA, w);
		chk(serial_out_data_out, w);
		chk({23'h0, seen}, 32'h0000_0004);
		acc(1'b0, 1'b0, MEM_MIR_DATA, 32'h0);
		chk(rdata, serial_in_data_in);
		chk({23'h0, seen}, 32'h0000_0001);
		acc(1'b1, 1'b0, {24'h0, IO_SERIAL_DATA}, 32'h0);
		chk(rdata, serial_in_data_in);
		chk({23'h0, seen}, 32'h0000_0001);
		acc(1'b0, 1'b0, MEM_MIR_CTRL, 32'h0);
		chk(rdata, serial_status_in);
		acc(1'b0, 1'b1, MEM_MIR_CTRL, ~w);
		chk(serial_control_out, ~w);
		chk({23'h0, seen}, 32'h0000_0002);
		acc(1'b0, 1'b1, MEM_MIR_ICTL, w ^ 32'h5A5A_5A5A);
		chk(serial_int_control_out, w ^ 32'h5A5A_5A5A);
		acc(1'b1, 1'b1, {24'h0, IO_SERIAL_ICTL}, w);
		chk(serial_int_control_out, w);
		acc(1'b1, 1'b0, 32'h0, 32'h0);
		chk(rdata, 32'h0);
		// scan window: read returns the scan data, both window ends strobe
		acc(1'b1, 1'b0, {24'h0, IO_SCAN_LO}, 32'h0);
		chk(rdata, {16'h0, w[31:16]});
		chk({23'h0, seen}, 32'h0000_0008);
		acc(1'b1, 1'b1, {24'h0, IO_SCAN_HI}, w);
		chk({23'h0, seen}, 32'h0000_0010);
		// shared memory plain and dma, global bus with the straps set, parallel bus
		acc(1'b0, 1'b1, {12'h0, w[19:0]}, w);
		chk({23'h0, seen}, 32'h0000_0100);
		acc(1'b0, 1'b0, MEM_DMA_SRAM_BASE | {12'h0, w[19:0]}, 32'h0);
		chk({23'h0, seen}, 32'h0000_0100);
		acc(1'b0, 1'b0, MEM_GBUS_HI, 32'h0);
		chk({23'h0, seen}, 32'h0000_0080);
		acc(1'b0, 1'b1, MEM_PBB_DATA_LO, w);
		chk({23'h0, seen}, 32'h0000_0040);
		acc(1'b0, 1'b0, MEM_PBB_DATA_HI + 32'h1, 32'h0);
		chk({23'h0, seen}, 32'h0000_0020);
		// a low site line strapped high takes the global bus window away
		@(posedge core_clk_in);
		site_address_line_7_in <= 1'b1;
		acc(1'b0, 1'b0, MEM_GBUS_LO, 32'h0);
		chk({23'h0, seen}, 32'h0000_0000);
		chk(rdata, 32'h0);
		// local bus decode: region edges first, then random addresses
		for (i = 0; i < 12; i++) begin
			@(posedge core_clk_in);
			lb_valid_in <= 1'b1;
			lb_addr_in <= (i < 6) ? edges[i] : $random(seed);
			@(posedge core_clk_in);
			@(negedge core_clk_in);
			w = {28'h0, lb_ap0_sel_out, lb_ap1_sel_out, lb_bridge_sel_out, lb_sram_sel_out};
			chk(w, exp_lb(lb_addr_in));
		end
		// interrupt sources at random, all quiet on the first pass
		for (i = 0; i < 10; i++) begin
			@(posedge core_clk_in);
			w = (i == 0) ? 32'h0 : $random(seed);
			{mailbox_wr_evt_in, mailbox_rd_evt_in, board_irq_src_in, host_to_dsp_irq_in} <= w[3:0];
			@(posedge core_clk_in);
			@(negedge core_clk_in);
			chk({31'h0, host_irq_out}, {31'h0, |w[3:1]});
			chk({29'h0, dsp_irq_line_out}, {29'h0, en & {3{w[0]}}});
		end
		print_verdict();
	end
endmodule : test_carrier_board_register_decoder
